// ---- pkg/mb_pkg.sv ----
// Overview of operation
// [RULE_01] only function codes 03h, 06h and 08h are executed; others are refused
// [RULE_02] read registers are 16 bits; at most 125 per query
// [RULE_03] multiple registers are fetched in ascending address order from the start
// [RULE_04] master reads both halves of a 32-bit value in one query
// [RULE_05] read query: address, 03h, start hi/lo, count hi/lo, CRC
// [RULE_06] read response: address, 03h, byte count of twice count, data, CRC
// [RULE_07] each register goes out upper byte first, then lower byte
// [RULE_08] every frame ends with CRC-16 over prior bytes, low byte first
// [RULE_09] write query: address, 06h, register hi/lo, value hi/lo, CRC
// [RULE_10] successful single write answers with a copy of the query
// [RULE_11] master updates paired halves with the multiple-register write; the slave refuses that function code with exception 01h
// [RULE_12] diagnosis echoes sub-function and data value unchanged
// [RULE_13] sub-function is 16 bits upper first; only 0000h is supported
// [RULE_14] exception answer is function code plus 80h, exception code, CRC
// [RULE_15] exception 01h for unknown function or nonzero sub-function
// [RULE_16] exception 02h for address above 57FFh or start plus count >= 5800h
// [RULE_17] exception 03h when zero registers are requested
// [RULE_18] frames with a wrong CRC are dropped without any answer
package mb_pkg;
    localparam logic [7:0] FC_READ = 8'h03;
    localparam logic [7:0] FC_WRITE = 8'h06;
    localparam logic [7:0] FC_DIAG = 8'h08;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_FUNC = 8'h01;
    localparam logic [7:0] EXC_ADDR = 8'h02;
    localparam logic [7:0] EXC_DATA = 8'h03;
    localparam logic [16:0] ADDR_LIMIT = 17'h05800;
    localparam logic [15:0] MAX_REGS = 16'h007D;
    localparam logic [15:0] DIAG_ECHO = 16'h0000;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [7:0] BROADCAST = 8'h00;
    localparam int QUERY_LEN = 8;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
    } byte_beat_t;

    typedef struct packed {
        logic req;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } reg_req_t;
endpackage

// ---- rtl/mb_crc16.sv ----
`timescale 1ns/1ps
module mb_crc16
    import mb_pkg::*;
(
    // control
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    // byte in
    input wire logic en,
    input wire logic [7:0] din,
    // result
    output logic [15:0] crc
);
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            crc <= CRC_INIT;
        end else if (clear) begin
            crc <= CRC_INIT;
        end else if (en) begin
            crc <= crc_step(crc, din);
        end
    end
endmodule

// ---- rtl/mb_slave.sv ----
`timescale 1ns/1ps
module mb_slave
    import mb_pkg::*;
#(
    parameter logic [7:0] SLAVE_ADDR = 8'h01
)(
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    // received bytes, last marks the frame end
    input wire byte_beat_t RX,
    // transmitted bytes, taken when TX_READY is high
    output byte_beat_t TX,
    input wire logic TX_READY,
    // register access, data returns next cycle
    output reg_req_t REG,
    input wire logic [15:0] REG_RDATA
);
    typedef enum logic [2:0] {
        S_RX = 3'b000,
        S_CHK = 3'b001,
        S_HDR = 3'b010,
        S_FETCH = 3'b011,
        S_DATA = 3'b100,
        S_CRC = 3'b101,
        S_DROP = 3'b110
    } state_t;

    state_t state_ff;
    logic [7:0] q_ff [QUERY_LEN];
    logic [3:0] cnt_ff;
    logic [15:0] reg_ptr_ff;
    logic [15:0] regs_left_ff;
    logic [15:0] rd_ff;
    logic [7:0] hdr_ff [6];
    logic [2:0] hdr_len_ff;
    logic [2:0] hi_ff;
    logic hi_byte_ff;
    logic crc_clr;
    logic crc_en;
    logic [7:0] crc_din;
    logic [15:0] crc;
    logic [7:0] nxt_exc;
    logic [15:0] q_addr, q_val;
    logic [16:0] q_end;
    logic tx_take;

    assign q_addr = {q_ff[2], q_ff[3]};
    assign q_val = {q_ff[4], q_ff[5]};
    assign q_end = {1'b0, q_addr} + {1'b0, q_val};
    assign tx_take = TX.valid && TX_READY;

    // one crc engine serves both the query check and the answer
    assign crc_clr = (state_ff == S_CHK) || (state_ff == S_DROP);
    assign crc_en = (state_ff == S_RX) ? (RX.valid && cnt_ff < 4'd8)
                                       : (tx_take && state_ff != S_CRC);
    assign crc_din = (state_ff == S_RX) ? RX.data : TX.data;

    mb_crc16 u_crc (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .clear(crc_clr),
        .en(crc_en),
        .din(crc_din),
        .crc(crc)
    );

    // exception priority: function, then count, then address
    always_comb begin
        nxt_exc = 8'h00;
        case (q_ff[1])
            FC_READ: begin
                if (q_val == 16'h0000 || q_val > MAX_REGS) begin
                    nxt_exc = EXC_DATA; // RULE_17
                end else if (q_end >= ADDR_LIMIT) begin
                    nxt_exc = EXC_ADDR; // RULE_16
                end
            end
            FC_WRITE: begin
                if ({1'b0, q_addr} >= ADDR_LIMIT) begin
                    nxt_exc = EXC_ADDR; // RULE_16
                end
            end
            FC_DIAG: begin
                if (q_addr != DIAG_ECHO) begin // RULE_13
                    nxt_exc = EXC_FUNC; // RULE_15
                end
            end
            default: nxt_exc = EXC_FUNC; // RULE_01
        endcase
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_ff <= S_RX;
            cnt_ff <= 4'h0;
            hi_ff <= 3'h0;
            hdr_len_ff <= 3'h0;
            reg_ptr_ff <= 16'h0000;
            regs_left_ff <= 16'h0000;
            rd_ff <= 16'h0000;
            hi_byte_ff <= 1'b1;
            TX <= '0;
            REG <= '0;
            for (int i = 0; i < QUERY_LEN; i++) begin
                q_ff[i] <= 8'h00;
            end
            for (int i = 0; i < 6; i++) begin
                hdr_ff[i] <= 8'h00;
            end
        end else begin
            REG.req <= 1'b0;
            case (state_ff)
                S_RX: begin
                    if (RX.valid) begin
                        if (cnt_ff < 4'd8) begin
                            q_ff[cnt_ff[2:0]] <= RX.data; // RULE_05 RULE_09
                            cnt_ff <= cnt_ff + 4'd1;
                        end
                        if (RX.last) begin
                            state_ff <= S_CHK;
                        end
                    end
                end
                S_CHK: begin
                    cnt_ff <= 4'h0;
                    // crc residue of a good frame with its trailer is zero
                    if (crc != 16'h0000 || cnt_ff != 4'd8 ||
                        q_ff[0] != SLAVE_ADDR) begin
                        state_ff <= S_DROP; // RULE_18
                    end else begin
                        hdr_ff[0] <= q_ff[0];
                        hi_ff <= 3'h0;
                        if (nxt_exc != 8'h00) begin
                            hdr_ff[1] <= q_ff[1] | EXC_FLAG; // RULE_14
                            hdr_ff[2] <= nxt_exc;
                            hdr_len_ff <= 3'd3;
                            regs_left_ff <= 16'h0000;
                        end else if (q_ff[1] == FC_READ) begin
                            hdr_ff[1] <= q_ff[1];
                            hdr_ff[2] <= {q_val[6:0], 1'b0}; // RULE_06
                            hdr_len_ff <= 3'd3;
                            reg_ptr_ff <= q_addr; // RULE_03
                            regs_left_ff <= q_val; // RULE_02
                        end else begin
                            for (int i = 1; i < 6; i++) begin
                                hdr_ff[i] <= q_ff[i]; // RULE_10 RULE_12
                            end
                            hdr_len_ff <= 3'd6;
                            regs_left_ff <= 16'h0000;
                            if (q_ff[1] == FC_WRITE) begin
                                REG <= '{1'b1, 1'b1, q_addr, q_val};
                            end
                        end
                        state_ff <= S_HDR;
                    end
                end
                S_HDR: begin
                    if (!TX.valid) begin
                        TX <= '{1'b1, hdr_ff[hi_ff], 1'b0};
                    end else if (TX_READY) begin
                        if (hi_ff + 3'd1 < hdr_len_ff) begin
                            hi_ff <= hi_ff + 3'd1;
                            TX <= '{1'b1, hdr_ff[hi_ff + 3'd1], 1'b0};
                        end else begin
                            TX.valid <= 1'b0;
                            state_ff <= (regs_left_ff != 16'h0000) ?
                                        S_FETCH : S_CRC;
                        end
                    end
                end
                S_FETCH: begin
                    if (!REG.req && !hi_byte_ff) begin
                        rd_ff <= REG_RDATA; // RULE_02
                        state_ff <= S_DATA;
                    end else if (hi_byte_ff) begin
                        REG <= '{1'b1, 1'b0, reg_ptr_ff, 16'h0000};
                        hi_byte_ff <= 1'b0;
                    end
                end
                S_DATA: begin
                    if (!TX.valid) begin
                        TX <= '{1'b1, hi_byte_ff ? rd_ff[7:0] : rd_ff[15:8],
                                1'b0}; // RULE_07
                    end else if (TX_READY) begin
                        TX.valid <= 1'b0;
                        if (!hi_byte_ff) begin
                            hi_byte_ff <= 1'b1;
                        end else begin
                            reg_ptr_ff <= reg_ptr_ff + 16'h0001; // RULE_03
                            regs_left_ff <= regs_left_ff - 16'h0001;
                            state_ff <= (regs_left_ff == 16'h0001) ?
                                        S_CRC : S_FETCH;
                        end
                    end
                end
                S_CRC: begin
                    if (!TX.valid) begin
                        TX <= '{1'b1, (cnt_ff == 4'h0) ? crc[7:0] : crc[15:8],
                                cnt_ff != 4'h0}; // RULE_08
                    end else if (TX_READY) begin
                        TX <= '0;
                        if (cnt_ff == 4'h0) begin
                            cnt_ff <= 4'h1;
                        end else begin
                            state_ff <= S_DROP;
                        end
                    end
                end
                S_DROP: begin
                    cnt_ff <= 4'h0;
                    hi_byte_ff <= 1'b1;
                    state_ff <= S_RX;
                end
                default: state_ff <= S_DROP;
            endcase
        end
    end

    // the hi_byte_ff fetch handshake: req pulses, data is latched after it

    property p_no_write_on_exc;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (state_ff == S_CHK && nxt_exc != 8'h00) |=> !(REG.req && REG.wr);
    endproperty
    a_no_write_on_exc: assert property (p_no_write_on_exc) // RULE_01
        else $error("register write on refused query");

    property p_bad_crc_silent;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (state_ff == S_CHK && crc != 16'h0000) |=> state_ff == S_DROP;
    endproperty
    a_bad_crc_silent: assert property (p_bad_crc_silent) // RULE_18
        else $error("bad crc frame answered");

    property p_exc_code;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (state_ff == S_CHK && state_ff != S_DROP && nxt_exc != 8'h00 &&
         crc == 16'h0000 && cnt_ff == 4'd8 && q_ff[0] == SLAVE_ADDR)
        |=> hdr_ff[1] == ($past(q_ff[1]) | EXC_FLAG) && hdr_len_ff == 3'd3;
    endproperty
    a_exc_code: assert property (p_exc_code) // RULE_14
        else $error("exception function code wrong");

    property p_zero_count;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (q_ff[1] == FC_READ && q_val == 16'h0000) |-> nxt_exc == EXC_DATA;
    endproperty
    a_zero_count: assert property (p_zero_count) // RULE_17
        else $error("zero count not refused");

    property p_addr_range;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (q_ff[1] == FC_READ && q_val != 16'h0000 && q_val <= MAX_REGS &&
         q_end >= ADDR_LIMIT) |-> nxt_exc == EXC_ADDR;
    endproperty
    a_addr_range: assert property (p_addr_range) // RULE_16
        else $error("address range not refused");

    property p_diag_sub;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (q_ff[1] == FC_DIAG && q_addr != DIAG_ECHO) |-> nxt_exc == EXC_FUNC;
    endproperty
    a_diag_sub: assert property (p_diag_sub) // RULE_15
        else $error("bad sub-function accepted");

    property p_ascending;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (REG.req && !REG.wr) |->
        REG.addr == q_addr + (q_val - regs_left_ff);
    endproperty
    a_ascending: assert property (p_ascending) // RULE_03
        else $error("read address not ascending");

    property p_crc_last;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (TX.valid && TX.last) |-> state_ff == S_CRC && cnt_ff == 4'h1;
    endproperty
    a_crc_last: assert property (p_crc_last) // RULE_08
        else $error("frame end without crc high byte");

    property p_max_regs;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        state_ff == S_FETCH |-> regs_left_ff <= MAX_REGS;
    endproperty
    a_max_regs: assert property (p_max_regs) // RULE_02
        else $error("register count above limit");

    c_read: cover property (@(posedge CLK_SYS) state_ff == S_DATA);
    c_write: cover property (@(posedge CLK_SYS) REG.req && REG.wr);
    c_exc: cover property (@(posedge CLK_SYS)
        state_ff == S_HDR && hdr_ff[1][7]);
    c_drop: cover property (@(posedge CLK_SYS)
        state_ff == S_CHK ##1 state_ff == S_DROP);
endmodule

// ---- bench/mb_master.sv ----
`timescale 1ns/1ps
module mb_master
    import mb_pkg::*;
(
    // clock
    input wire logic clk,
    // query bytes toward the slave
    output byte_beat_t rx,
    // answer bytes from the slave
    input wire byte_beat_t tx,
    output logic tx_ready
);
    logic [7:0] got[$];
    logic done;
    logic slow;

    initial begin
        rx = '0;
        tx_ready = 1'b0;
        slow = 1'b0;
        done = 1'b0;
    end

    function automatic logic [15:0] crc(input logic [7:0] b[$]);
        logic [15:0] c;
        c = CRC_INIT;
        foreach (b[i]) begin
            c ^= {8'h00, b[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
        end
        return c;
    endfunction

    // a bad check value is the inverse of the right one
    task automatic send(input logic [7:0] b[$], input logic good);
        logic [15:0] c;
        got = {};
        done = 1'b0;
        c = crc(b);
        if (!good) c = ~c;
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        foreach (b[i]) begin
            @(posedge clk);
            rx <= '{valid: 1'b1, data: b[i], last: i == b.size() - 1};
            @(posedge clk);
            // idle data is scrambled so a stale byte never looks valid
            rx <= '{1'b0, ~b[i], 1'b0};
        end
    endtask

    task automatic recv(output logic [7:0] r[$], input int lim);
        repeat (lim) begin
            @(posedge clk);
            if (done) break;
        end
        #1;
        r = got;
        got = {};
        done = 1'b0;
    endtask

    // slow mode drops tx_ready on every other cycle
    always @(posedge clk) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (tx.valid && tx_ready) begin
            got.push_back(tx.data);
            if (tx.last) done <= 1'b1;
        end
    end
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb
    import mb_pkg::*;
;
    logic CLK_SYS;
    logic SYS_RST;
    byte_beat_t RX;
    byte_beat_t TX;
    logic TX_READY;
    reg_req_t REG;
    logic [15:0] REG_RDATA;
    logic [15:0] mem [logic [15:0]];
    int errors;
    int check_count;

    mb_slave #(.SLAVE_ADDR(8'h01)) uut (
        .CLK_SYS(CLK_SYS),
        .SYS_RST(SYS_RST),
        .RX(RX),
        .TX(TX),
        .TX_READY(TX_READY),
        .REG(REG),
        .REG_RDATA(REG_RDATA)
    );

    mb_master m (
        .clk(CLK_SYS),
        .rx(RX),
        .tx(TX),
        .tx_ready(TX_READY)
    );

    function automatic logic [15:0] rd(input logic [15:0] a);
        return mem.exists(a) ? mem[a] : a ^ 16'h5A0F;
    endfunction

    // read data holds for one cycle only, then turns to garbage
    initial REG_RDATA = 16'h0000;
    always @(posedge CLK_SYS) begin
        if (REG.req && REG.wr) mem[REG.addr] = REG.wdata;
        if (REG.req && !REG.wr) REG_RDATA <= rd(REG.addr);
        else REG_RDATA <= ~REG_RDATA;
    end

    task automatic chk8(input string what, input logic [7:0] e,
                        input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic xact(input logic [7:0] q[$], input logic [7:0] e[$]);
        logic [7:0] r[$];
        logic [15:0] c;
        c = m.crc(e);
        e.push_back(c[7:0]);
        e.push_back(c[15:8]);
        m.send(q, 1'b1);
        m.recv(r, 2000);
        chk8("answer length", 8'(e.size()), 8'(r.size()));
        foreach (e[i]) if (i < r.size()) chk8("answer byte", e[i], r[i]);
    endtask

    task automatic read_ok(input logic [15:0] s, input logic [7:0] n);
        logic [7:0] e[$];
        logic [15:0] d;
        e = {8'h01, FC_READ, 8'(2 * n)};
        for (int i = 0; i < n; i++) begin
            d = rd(s + 16'(i));
            e.push_back(d[15:8]);
            e.push_back(d[7:0]);
        end
        xact({8'h01, FC_READ, s[15:8], s[7:0], 8'h00, n}, e);
    endtask

    task automatic exc(input logic [7:0] q[$], input logic [7:0] code);
        xact(q, {8'h01, q[1] + 8'h80, code});
    endtask

    task automatic drop(input logic [7:0] q[$], input logic good);
        logic [7:0] r[$];
        m.send(q, good);
        m.recv(r, 40);
        chk8("silent frame", 8'h00, 8'(r.size()));
    endtask

    task automatic t_echo();
        logic [7:0] w[$];
        w = {8'h01, FC_WRITE, 8'h10, 8'h4B, 8'h03, 8'hE8};
        xact(w, w);
        read_ok(16'h104B, 8'h01);
        w = {8'h01, FC_DIAG, 8'h00, 8'h00, 8'h12, 8'h34};
        xact(w, w);
        exc({8'h01, FC_DIAG, 8'h00, 8'h01, 8'h12, 8'h34}, 8'h01);
    endtask

    task automatic t_refuse();
        logic [7:0] fc[$];
        fc = {8'h01, 8'h04, 8'h10, 8'h17, 8'h2B};
        foreach (fc[i]) exc({8'h01, fc[i], 8'h00, 8'h00, 8'h00, 8'h01},
                            8'h01);
        exc({8'h01, FC_READ, 8'h00, 8'h00, 8'h00, 8'h00}, 8'h03);
        exc({8'h01, FC_READ, 8'h00, 8'h00, 8'h00, 8'h7E}, 8'h03);
        exc({8'h01, FC_READ, 8'h57, 8'hFF, 8'h00, 8'h02}, 8'h02);
        exc({8'h01, FC_WRITE, 8'h58, 8'h00, 8'h00, 8'h01}, 8'h02);
        chk8("refused write", 8'h00, 8'(mem.exists(16'h5800)));
    endtask

    task automatic t_drop();
        drop({8'h01, FC_READ, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0);
        drop({8'h02, FC_READ, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b1);
        drop({BROADCAST, FC_WRITE, 8'h01, 8'h00, 8'h00, 8'h07}, 1'b1);
        chk8("broadcast write", 8'h00, 8'(mem.exists(16'h0100)));
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        CLK_SYS = 1'b0;
        forever #12.5 CLK_SYS = ~CLK_SYS;
    end

    // longest run is under two thousand cycles, so 40000 means a hang
    initial begin
        #(25 * 40000);
        errors++;
        tally_and_finish();
    end

    initial begin
        errors = 0;
        check_count = 0;
        SYS_RST = 1'b1;
        repeat (2) @(posedge CLK_SYS);
        SYS_RST <= 1'b0;
        read_ok(16'h0480, 8'h04);
        m.slow = 1'b1;
        read_ok(16'h5782, 8'h7D);
        m.slow = 1'b0;
        t_echo();
        t_refuse();
        t_drop();
        tally_and_finish();
    end
endmodule
